// file: hdl/fuc_defines.vh
`ifndef FUC_DEFINES_VH
`define FUC_DEFINES_VH
// register byte addresses
`define FUC_A_BAUD 32'h30001800
`define FUC_A_TXD 32'h30001804
`define FUC_A_RXD 32'h30001808
`define FUC_A_CTRL 32'h3000180C
`define FUC_A_MASK 32'h30001810
`define FUC_A_STAT 32'h30001814
`define FUC_A_GUARD 32'h30001818
`define FUC_A_TOUT 32'h3000181C
`define FUC_A_TXFL 32'h30001820
`define FUC_A_RXFL 32'h30001824
// reset values
`define FUC_BAUD_RST 16'h0001
`define FUC_CTRL_RST 11'h000
// line control fields
`define FUC_C_FIFO 10
`define FUC_C_RXEN 8
`define FUC_C_RUN 7
`define FUC_C_LOOP 6
`define FUC_C_PAR 5
`define FUC_C_STOP 4:3
`define FUC_C_MODE 2:0
// line status bits
`define FUC_S_RXAV 0
`define FUC_S_TXE 1
`define FUC_S_HALT 2
`define FUC_S_ERR 5:3
`define FUC_S_TONE 6
`define FUC_S_TOID 7
`define FUC_S_RXHF 8
`define FUC_S_TXF 9
// frame types
`define FUC_M_D7P 3'h3
`define FUC_M_D9 3'h4
`define FUC_M_D8W 3'h5
`define FUC_M_D8P 3'h7
// sixteen-times clock phases
`define FUC_PH_MID 4'h7
`define FUC_PH_END 4'hF
`define FUC_STOP_UNIT 6'h08
`endif

// file: hdl/fuc_fifo.v
`timescale 1ns/100ps
`default_nettype none
// synchronous queue with flush; reads show the head combinationally
module fuc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire flush,
  input wire push,
  input wire [WIDTH-1:0] din,
  input wire pop,
  // state
  output wire [WIDTH-1:0] dout,
  output reg [AW:0] count,
  output wire full,
  output wire empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  wire do_push = push & ~full;
  wire do_pop = pop & ~empty;

  assign dout = mem[rp];
  assign full = (count == DEPTH[AW:0]);
  assign empty = (count == {(AW+1){1'b0}});

  // storage has no reset; only pointers matter
  always @(posedge pclk)
  begin
    if (do_push)
      mem[wp] <= din;
  end

  // pointers and fill level; flush wins over traffic
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wp <= wp + {{(AW-1){1'b0}}, 1'b1};
      if (do_pop)
        rp <= rp + {{(AW-1){1'b0}}, 1'b1};
      if (do_push & ~do_pop)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (do_pop & ~do_push)
        count <= count - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // fuc_fifo
`default_nettype wire

// file: hdl/fuc_rx.v
`timescale 1ns/100ps
`default_nettype none
`include "fuc_defines.vh"
// receive deserialiser on the sixteen-times clock
module fuc_rx (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire enable,
  input wire tick16,
  input wire rxd,
  input wire [2:0] mode,
  input wire podd,
  // result
  output reg done,
  output reg [8:0] data,
  output reg ferr,
  output reg perr
);
  localparam R_IDLE = 2'h0;
  localparam R_START = 2'h1;
  localparam R_DATA = 2'h2;
  localparam R_STOP = 2'h3;
  reg [1:0] st;
  reg [3:0] ph;
  reg [3:0] n;
  reg [8:0] sh;
  wire nine = (mode == `FUC_M_D9) | (mode == `FUC_M_D8W) | (mode == `FUC_M_D8P);
  wire [8:0] w = nine ? sh : {1'b0, sh[8:1]};
  reg [8:0] dword;
  reg pbad;

  // split the received word into data and parity
  always @*
  begin
    dword = {1'b0, w[7:0]};
    pbad = 1'b0;
    case (mode)
      `FUC_M_D7P:
      begin
        dword = {2'h0, w[6:0]};
        pbad = w[7] != ((^w[6:0]) ^ podd);
      end
      `FUC_M_D9, `FUC_M_D8W: dword = w;
      `FUC_M_D8P: pbad = w[8] != ((^w[7:0]) ^ podd);
      default: dword = {1'b0, w[7:0]};
    endcase
  end

  // start, data lsb first, stop; each sampled mid-bit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= R_IDLE;
      ph <= 4'h0;
      n <= 4'h0;
      sh <= 9'h000;
      done <= 1'b0;
      data <= 9'h000;
      ferr <= 1'b0;
      perr <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!enable)
        st <= R_IDLE;
      else if (tick16)
      begin
        ph <= ph + 4'h1;
        case (st)
          R_IDLE:
          begin
            ph <= 4'h0;
            if (!rxd)
              st <= R_START;
          end
          R_START:
            if (ph == `FUC_PH_MID)
            begin
              ph <= 4'h0;
              n <= nine ? 4'h8 : 4'h7;
              st <= rxd ? R_IDLE : R_DATA; // glitch rejected at centre
            end
          R_DATA:
            if (ph == `FUC_PH_END)
            begin
              sh <= {rxd, sh[8:1]};
              n <= n - 4'h1;
              if (n == 4'h0)
                st <= R_STOP;
            end
          R_STOP:
            if (ph == `FUC_PH_END)
            begin
              done <= 1'b1;
              data <= dword;
              ferr <= ~rxd;
              perr <= pbad;
              st <= R_IDLE;
            end
          default: st <= R_IDLE;
        endcase
      end
    end
  end
endmodule // fuc_rx
`default_nettype wire

// file: hdl/fuc_uart.v
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "fuc_defines.vh"
module fuc_uart #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // serial lines
  output wire txd,
  input wire rxd,
  // interrupt
  output reg irq
);
  localparam T_IDLE = 2'h0;
  localparam T_START = 2'h1;
  localparam T_DATA = 2'h2;
  localparam T_STOP = 2'h3;

  reg [15:0] div;
  reg [10:0] ctrl;
  reg [8:0] mask;
  reg [7:0] guard;
  reg [7:0] tout;
  reg rdy;
  reg [15:0] bcnt;
  reg [3:0] bph;
  reg [8:0] gap;
  reg [7:0] gcnt;
  reg [8:0] thold;
  reg thold_v;
  reg [9:0] rhold;
  reg rhold_v;
  reg [2:0] err;
  reg [1:0] tst;
  reg [3:0] tph;
  reg [5:0] tstop;
  reg [8:0] tsh;
  reg [3:0] tn;
  reg txo;
  reg [8:0] tword;
  reg [3:0] tcount;
  reg [31:0] rmux;

  wire fifo_en = ctrl[`FUC_C_FIFO];
  wire run = ctrl[`FUC_C_RUN];
  wire rx_en = run & ctrl[`FUC_C_RXEN];
  wire loop = ctrl[`FUC_C_LOOP];
  wire podd = ctrl[`FUC_C_PAR];
  wire [2:0] mode = ctrl[`FUC_C_MODE];

  // apb decode; one wait state gives the read mux a flop stage
  wire acc = psel & penable;
  wire fin = acc & rdy;
  wire h_baud = paddr == `FUC_A_BAUD;
  wire h_txd = paddr == `FUC_A_TXD;
  wire h_rxd = paddr == `FUC_A_RXD;
  wire h_ctrl = paddr == `FUC_A_CTRL;
  wire h_mask = paddr == `FUC_A_MASK;
  wire h_stat = paddr == `FUC_A_STAT;
  wire h_guard = paddr == `FUC_A_GUARD;
  wire h_tout = paddr == `FUC_A_TOUT;
  wire h_txfl = paddr == `FUC_A_TXFL;
  wire h_rxfl = paddr == `FUC_A_RXFL;
  wire mapped = h_baud | h_txd | h_rxd | h_ctrl | h_mask | h_stat | h_guard | h_tout
    | h_txfl | h_rxfl;
  wire wr = fin & pwrite;
  wire rd = fin & ~pwrite;
  assign pready = rdy;
  assign pslverr = rdy & ~mapped;

  // baud generator: sixteen-times tick every div clocks
  wire tick16 = run & ((bcnt >= div - 16'h0001) | (div == 16'h0000));
  wire btick = tick16 & (bph == `FUC_PH_END);

  // queue wiring
  wire txq_full;
  wire txq_empty;
  wire [AW:0] txq_cnt;
  wire [8:0] txq_dout;
  wire rxq_full;
  wire rxq_empty;
  wire [AW:0] rxq_cnt;
  wire [9:0] rxq_dout;
  wire rx_done;
  wire [8:0] rx_data;
  wire rx_ferr;
  wire rx_perr;

  wire src_av = fifo_en ? ~txq_empty : thold_v;
  wire [8:0] src_d = fifo_en ? txq_dout : thold;
  wire take = tick16 & (tst == T_IDLE) & src_av;
  wire tx_push = wr & h_txd & fifo_en;
  wire tx_flush = wr & h_txfl;
  wire rx_flush = wr & h_rxfl;
  wire rx_full = fifo_en ? rxq_full : rhold_v;
  wire rx_av = fifo_en ? ~rxq_empty : rhold_v;
  wire rx_pop = rd & h_rxd;
  wire ovr = rx_done & rx_full;
  wire [9:0] rx_entry = {rx_ferr | rx_perr, rx_data};

  fuc_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_txq (
    .pclk(pclk),
    .presetn(presetn),
    .flush(tx_flush),
    .push(tx_push),
    .din(pwdata[8:0]),
    .pop(take & fifo_en),
    .dout(txq_dout),
    .count(txq_cnt),
    .full(txq_full),
    .empty(txq_empty)
  );

  fuc_fifo #(.WIDTH(10), .DEPTH(DEPTH), .AW(AW)) u_rxq (
    .pclk(pclk),
    .presetn(presetn),
    .flush(rx_flush),
    .push(rx_done & fifo_en),
    .din(rx_entry),
    .pop(rx_pop & fifo_en),
    .dout(rxq_dout),
    .count(rxq_cnt),
    .full(rxq_full),
    .empty(rxq_empty)
  );

  // loopback feeds the receiver from the transmitter
  fuc_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .enable(rx_en),
    .tick16(tick16),
    .rxd(loop ? txo : rxd),
    .mode(mode),
    .podd(podd),
    .done(rx_done),
    .data(rx_data),
    .ferr(rx_ferr),
    .perr(rx_perr)
  );
  assign txd = loop | txo;

  // status word
  wire tx_empty = (tst == T_IDLE) & ~src_av & (gcnt == 8'h00);
  wire to_hit = rx_en & (gap > {1'b0, tout});
  wire [9:0] status;
  assign status[`FUC_S_RXAV] = rx_av;
  assign status[`FUC_S_TXE] = tx_empty;
  assign status[`FUC_S_HALT] = fifo_en ? (txq_cnt <= DEPTH / 2) : ~thold_v;
  assign status[`FUC_S_ERR] = err;
  assign status[`FUC_S_TONE] = to_hit & rx_av;
  assign status[`FUC_S_TOID] = to_hit & ~rx_av;
  assign status[`FUC_S_RXHF] = fifo_en & (rxq_cnt >= DEPTH / 2);
  assign status[`FUC_S_TXF] = fifo_en ? txq_full : thold_v;

  // read mux; reserved bits read zero, except control bit 9, which reads back as written
  always @*
  begin
    rmux = 32'h00000000;
    if (h_baud)
      rmux = {16'h0000, div};
    if (h_rxd)
      rmux = {22'h000000, fifo_en ? rxq_dout : rhold};
    if (h_ctrl)
      rmux = {21'h000000, ctrl};
    if (h_mask)
      rmux = {23'h000000, mask};
    if (h_stat)
      rmux = {22'h000000, status};
    if (h_guard)
      rmux = {24'h000000, guard};
    if (h_tout)
      rmux = {24'h000000, tout};
  end

  // bus handshake, data capture and writable registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy <= 1'b0;
      prdata <= 32'h00000000;
      div <= `FUC_BAUD_RST;
      ctrl <= `FUC_CTRL_RST;
      mask <= 9'h000;
      guard <= 8'h00;
      tout <= 8'h00;
    end
    else
    begin
      rdy <= acc & ~rdy;
      if (acc & ~rdy)
        prdata <= pwrite ? 32'h00000000 : rmux;
      if (wr & h_baud)
        div <= pwdata[15:0];
      if (wr & h_ctrl)
        ctrl <= pwdata[10:0];
      if (wr & h_mask)
        mask <= pwdata[8:0];
      if (wr & h_guard)
        guard <= pwdata[7:0];
      if (wr & h_tout)
        tout <= pwdata[7:0];
    end
  end

  // sticky errors clear only where a status read showed them; set wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err <= 3'h0;
    else
      err <= (err & ~((rd & h_stat) ? prdata[`FUC_S_ERR] : 3'h0))
        | {ovr, rx_done & rx_ferr, rx_done & rx_perr};
  end

  // unmasked conditions drive the interrupt
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status[8:0] & mask);
  end

  // bypass holding registers stand in for the queues
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thold <= 9'h000;
      thold_v <= 1'b0;
      rhold <= 10'h000;
      rhold_v <= 1'b0;
    end
    else
    begin
      if (tx_flush | (take & ~fifo_en))
        thold_v <= 1'b0;
      else if (wr & h_txd & ~fifo_en & ~thold_v)
      begin
        thold <= pwdata[8:0];
        thold_v <= 1'b1;
      end
      if (rx_done & ~fifo_en & ~rhold_v)
      begin
        rhold <= rx_entry;
        rhold_v <= 1'b1;
      end
      else if (rx_flush | (rx_pop & ~fifo_en))
        rhold_v <= 1'b0;
    end
  end

  // bit-time base, receive gap and transmit guard counters
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bcnt <= 16'h0000;
      bph <= 4'h0;
      gap <= 9'h000;
      gcnt <= 8'h00;
    end
    else
    begin
      if (!run || tick16)
        bcnt <= 16'h0000;
      else
        bcnt <= bcnt + 16'h0001;
      if (tick16)
        bph <= bph + 4'h1;
      if (rx_done || !rx_en)
        gap <= 9'h000;
      else if (btick && !gap[8])
        gap <= gap + 9'h001;
      if (tick16 && (tst == T_STOP) && (tstop == 6'h00))
        gcnt <= guard;
      else if (take)
        gcnt <= 8'h00;
      else if (btick && (gcnt != 8'h00))
        gcnt <= gcnt - 8'h01;
    end
  end

  // frame word and bit count per frame type
  always @*
  begin
    tword = {1'b0, src_d[7:0]};
    tcount = 4'h7;
    case (mode)
      `FUC_M_D7P: tword = {1'b0, (^src_d[6:0]) ^ podd, src_d[6:0]};
      `FUC_M_D9, `FUC_M_D8W:
      begin
        tword = src_d;
        tcount = 4'h8;
      end
      `FUC_M_D8P:
      begin
        tword = {(^src_d[7:0]) ^ podd, src_d[7:0]};
        tcount = 4'h8;
      end
      default: tword = {1'b0, src_d[7:0]};
    endcase
  end

  // transmit serialiser: start, data lsb first, stop period
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tst <= T_IDLE;
      tph <= 4'h0;
      tstop <= 6'h00;
      tsh <= 9'h000;
      tn <= 4'h0;
      txo <= 1'b1;
    end
    else if (!run)
    begin
      tst <= T_IDLE;
      txo <= 1'b1;
    end
    else if (tick16)
    begin
      tph <= tph + 4'h1;
      case (tst)
        T_IDLE:
          if (take)
          begin
            tsh <= tword;
            tn <= tcount;
            tph <= 4'h0;
            txo <= 1'b0;
            tst <= T_START;
          end
        T_START, T_DATA:
          if (tph == `FUC_PH_END)
          begin
            if (tst == T_DATA && tn == 4'h0)
            begin
              txo <= 1'b1;
              tstop <= {ctrl[`FUC_C_STOP], 3'h0} + `FUC_STOP_UNIT - 6'h01;
              tst <= T_STOP;
            end
            else
            begin
              txo <= tsh[0];
              tsh <= {1'b0, tsh[8:1]};
              if (tst == T_DATA)
                tn <= tn - 4'h1;
              tst <= T_DATA;
            end
          end
        T_STOP:
          if (tstop == 6'h00)
            tst <= T_IDLE;
          else
            tstop <= tstop - 6'h01;
        default: tst <= T_IDLE;
      endcase
    end
  end
endmodule // fuc_uart
`default_nettype wire

// file: testbench/fuc_uart_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "fuc_defines.vh"
// port-level watcher for the serial port block
module fuc_uart_monitor #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // serial lines and interrupt
  input wire logic txd,
  input wire logic rxd,
  input wire logic irq
);
  logic [10:0] ctrl_q;
  logic [8:0] mask_q;
  logic wr_done;
  logic unmapped;
  assign wr_done = psel && penable && pready && pwrite;
  // anything outside the ten aligned words must be refused
  assign unmapped = (paddr[31:6] != 26'h0C00060) || (paddr[5:0] > 6'h24) || (paddr[1:0] != 2'h0);
  // shadows follow writes at the completing edge, as the slave does
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= 11'h000;
      mask_q <= 9'h000;
    end
    else if (wr_done && paddr == `FUC_A_CTRL)
      ctrl_q <= pwdata[10:0];
    else if (wr_done && paddr == `FUC_A_MASK)
      mask_q <= pwdata[8:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // start bit: sixteen ticks even at the fastest divisor
  sequence start_half;
    (!txd) [*8];
  endsequence
  sequence start_bit;
    start_half ##1 start_half;
  endsequence
  sequence apb_access;
    psel && !penable ##1 psel && penable;
  endsequence
  chk_start_length: assert property ($fell(txd) |-> start_bit)
    else $error("start bit too short");
  chk_ready_once: assert property (apb_access |=> pready ##1 !pready)
    else $error("ready not a single pulse after first access cycle");
  chk_slverr_map: assert property (pready && psel |-> pslverr == unmapped)
    else $error("error response does not match address map");
  chk_wo_reads: assert property (pready && psel && !pwrite
      && (paddr == `FUC_A_TXD || paddr == `FUC_A_TXFL) |-> prdata == 32'h00000000)
    else $error("write-only port read not zero");
  chk_ctrl_back: assert property (pready && psel && !pwrite
      && paddr == `FUC_A_CTRL |-> prdata == {21'h000000, ctrl_q})
    else $error("control readback differs from last write");
  chk_irq_masked: assert property ((mask_q == 9'h000) [*3] |-> !irq)
    else $error("interrupt raised with every source masked");
  chk_loop_quiet: assert property (ctrl_q[6] [*3] |-> txd)
    else $error("line driven during internal loop");
  chk_run_quiet: assert property (!ctrl_q[7] [*3] |-> txd)
    else $error("line driven with baud generator stopped");
endmodule // fuc_uart_monitor
bind fuc_uart fuc_uart_monitor #(.DEPTH(DEPTH), .AW(AW)) u_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .txd(txd),
  .rxd(rxd), .irq(irq));
`default_nettype wire

// file: testbench/fuc_remote.sv
`timescale 1ns/100ps
`default_nettype none
// far-end transceiver: frames onto the receive line, decodes the transmit line
module fuc_remote (
  // clock and frame setup
  input wire logic pclk,
  input wire logic [15:0] div,
  input wire logic [3:0] nbits,
  // serial lines
  input wire logic txd,
  output logic rxd
);
  logic [9:0] got = 10'h000;
  int got_n = 0;
  initial rxd = 1'b1;
  // whole ticks of the sixteen-times clock; zero acts as one
  task automatic ticks(input int n);
    repeat (n * ((div == 16'h0000) ? 1 : div)) @(posedge pclk);
  endtask
  // one frame, lsb first; a low stop level makes a framing fault on request
  task automatic send(input logic [9:0] w, input logic stop_lvl);
    @(posedge pclk);
    rxd <= 1'b0;
    ticks(16);
    for (int i = 0; i < nbits; i++)
    begin
      rxd <= w[i];
      ticks(16);
    end
    rxd <= stop_lvl;
    ticks(16);
    rxd <= 1'b1;
  endtask
  // centre sampling; frames are not expected back to back here
  always
  begin
    @(negedge txd);
    got = 10'h000;
    ticks(8);
    for (int j = 0; j < nbits; j++)
    begin
      ticks(16);
      got[j] = txd;
    end
    ticks(16);
    got_n++;
  end
endmodule // fuc_remote
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "fuc_defines.vh"
`define CHK(n, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("unexpected %s exp %0h got %0h", n, e, g); \
    end \
  end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, rxd, irq, serr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [15:0] div;
  logic [3:0] nb;
  logic [2:0] modes [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
  // control bit 9 is reserved and must be written as zero, so it is never set here
  logic [15:0] rw_mask [5] = '{16'hFFFF, 16'h05FF, 16'h01FF, 16'h00FF, 16'h00FF};
  int rw_idx [5] = '{0, 3, 4, 6, 7};
  int error_cnt = 0;
  int check_count = 0;
  int k, n0;
  fuc_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .txd(txd), .rxd(rxd), .irq(irq));
  fuc_remote rem (.pclk(pclk), .div(div), .nbits(nb), .txd(txd), .rxd(rxd));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // one transfer; request held until pready is seen high at an edge
  task automatic apb(input logic [31:0] a, input logic [31:0] d, input logic w);
    int i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 40);
    if (pready !== 1'b1)
      error_cnt++;
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for the far end to finish decoding a frame
  task automatic wait_rx(input int n);
    for (int i = 0; i < 4000 && rem.got_n == n; i++) @(posedge pclk);
    if (rem.got_n == n) error_cnt++;
  endtask
  function automatic logic [9:0] frame(input logic [2:0] m, input logic p, input logic [8:0] d);
    case (m)
      3'h3: frame = {2'h0, (^d[6:0]) ^ p, d[6:0]};
      3'h7: frame = {1'b0, (^d[7:0]) ^ p, d[7:0]};
      3'h1: frame = {2'h0, d[7:0]};
      default: frame = {1'b0, d};
    endcase
  endfunction
  task finish_test;
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // the sequence needs some 5k cycles; a hang is cut at 90k
  initial
  begin
    #720000;
    error_cnt++;
    finish_test;
  end
  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    div = 16'h0001;
    nb = 4'h8;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 8; k++)
    begin
      apb(`FUC_A_BAUD + 4 * k, 32'h0, 1'b0);
      `CHK("reset value", (k == 0) ? 32'h1 : (k == 5) ? 32'h6 : 32'h0, rdat)
    end
    apb(32'h30001828, 32'h0, 1'b1);
    `CHK("unmapped error", 1'b1, serr)
    for (k = 0; k < 5; k++)
    begin
      apb(`FUC_A_BAUD + 4 * rw_idx[k], (k == 1) ? 32'hFDFF : 32'hFFFF, 1'b1);
      apb(`FUC_A_BAUD + 4 * rw_idx[k], 32'h0, 1'b0);
      `CHK("register field", {16'h0, rw_mask[k]}, rdat)
      apb(`FUC_A_BAUD + 4 * rw_idx[k], (k == 0) ? 32'h1 : 32'h0, 1'b1);
    end
    // every frame type, parity sense alternating
    for (k = 0; k < 5; k++)
    begin
      nb <= (modes[k] == 3'h1 || modes[k] == 3'h3) ? 4'h8 : 4'h9;
      apb(`FUC_A_CTRL, 32'h88 + 32 * (k % 2) + modes[k], 1'b1);
      n0 = rem.got_n;
      apb(`FUC_A_TXD, 32'h1C3 - k, 1'b1);
      wait_rx(n0);
      `CHK("sent frame", frame(modes[k], k[0], 9'(9'h1C3 - k)), rem.got)
    end
    // receive good, bad parity, bad stop, then an overrun
    apb(`FUC_A_CTRL, 32'h18F, 1'b1);
    apb(`FUC_A_TOUT, 32'h2, 1'b1);
    rem.send(frame(3'h7, 1'b0, 9'h05A), 1'b1);
    repeat (80) @(posedge pclk);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("data timeout", 3'h3, {rdat[7], rdat[6], rdat[0]})
    apb(`FUC_A_RXD, 32'h0, 1'b0);
    `CHK("received word", 9'h05A, {rdat[9], rdat[7:0]})
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("idle timeout", 2'h2, {rdat[7], rdat[0]})
    rem.send(frame(3'h7, 1'b0, 9'h05A) ^ 10'h100, 1'b1);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("parity flag", 1'b1, rdat[3])
    apb(`FUC_A_RXD, 32'h0, 1'b0);
    `CHK("entry error", 1'b1, rdat[9])
    rem.send(frame(3'h7, 1'b0, 9'h0A5), 1'b0);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("framing flag", 1'b1, rdat[4])
    rem.send(frame(3'h7, 1'b0, 9'h03C), 1'b1);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("overrun flag", 1'b1, rdat[5])
    apb(`FUC_A_RXD, 32'h0, 1'b0);
    `CHK("kept word", 9'h1A5, {rdat[9], rdat[7:0]})
    apb(`FUC_A_CTRL, 32'h08F, 1'b1);
    rem.send(frame(3'h7, 1'b0, 9'h011), 1'b1);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("receiver off", 1'b0, rdat[0])
    // queued loopback: nine words round inside, line stays quiet
    apb(`FUC_A_CTRL, 32'h5CF, 1'b1);
    n0 = rem.got_n;
    for (k = 0; k < 9; k++)
      apb(`FUC_A_TXD, 32'h30 + k, 1'b1);
    repeat (1800) @(posedge pclk);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("rx half full", 2'h3, {rdat[8], rdat[0]})
    for (k = 0; k < 3; k++)
    begin
      apb(`FUC_A_RXD, 32'h0, 1'b0);
      `CHK("looped word", 32'h30 + k, {24'h0, rdat[7:0]})
    end
    `CHK("line quiet", n0, rem.got_n)
    apb(`FUC_A_RXFL, 32'h0, 1'b1);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("rx flushed", 1'b0, rdat[0])
    apb(`FUC_A_CTRL, 32'h400, 1'b1);
    for (k = 0; k < 16; k++)
      apb(`FUC_A_TXD, k, 1'b1);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("tx full", 2'h2, {rdat[9], rdat[2]})
    apb(`FUC_A_TXFL, 32'h0, 1'b1);
    apb(`FUC_A_STAT, 32'h0, 1'b0);
    `CHK("tx flushed", 2'h1, {rdat[9], rdat[2]})
    // guard delay before transmit empty, seen through the interrupt
    apb(`FUC_A_CTRL, 32'h089, 1'b1);
    nb <= 4'h8;
    apb(`FUC_A_GUARD, 32'h4, 1'b1);
    n0 = rem.got_n;
    apb(`FUC_A_TXD, 32'h55, 1'b1);
    apb(`FUC_A_MASK, 32'h2, 1'b1);
    wait_rx(n0);
    `CHK("sent byte", 10'h055, rem.got)
    // past the stop period a missing guard would already have raised the interrupt
    repeat (20) @(posedge pclk);
    `CHK("guard running", 1'b0, irq)
    repeat (120) @(posedge pclk);
    `CHK("empty interrupt", 1'b1, irq)
    apb(`FUC_A_MASK, 32'h0, 1'b1);
    repeat (3) @(posedge pclk);
    `CHK("masked interrupt", 1'b0, irq)
    // divisor two doubles the bit time
    apb(`FUC_A_BAUD, 32'h2, 1'b1);
    div <= 16'h0002;
    n0 = rem.got_n;
    apb(`FUC_A_TXD, 32'hA7, 1'b1);
    @(negedge txd);
    @(negedge pclk);
    for (k = 0; txd === 1'b0 && k < 100; k++) @(negedge pclk);
    `CHK("start length", 32, k)
    wait_rx(n0);
    `CHK("slow byte", 10'h0A7, rem.got)
    finish_test;
  end
endmodule // testbench
`default_nettype wire
